// ### rtl/tdcd_decode.sv
// Function
// - Done request sets sticky transmit-done status once the frame has gone out.
// - Done request honoured only with last segment or setup frame.
// - Last segment flag ends the current frame.
// - First segment flag starts a new frame.
// - Filter codes: perfect 16, hash plus one, inverse, hash-only 512-bit.
// - Filter type only meaningful when setup frame flag is set.
// - Setup frame flag marks the buffer as setup data.
// - CRC inhibit suppresses the appended check sequence.
// - CRC inhibit sampled only from first segment descriptors.
// - Ring wrap sends the next fetch to the list base.
// - Chain flag makes second address the next descriptor.
// - Ring wrap beats chaining when both are set.
// - Pad inhibit stops padding of short frames.
// - Pad enabled forces padding and CRC on short frames.
// - Buffer 2 count in bits 21:11; zero skips it.
// - Buffer 2 count ignored while chaining.
// - Buffer 1 count zero skips to buffer 2.
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module tdcd_decode
    import tdcd_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // AXI4-Lite slave
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    output logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    input wire logic [7:0] s_axi_araddr_i,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    // Descriptor fetch path
    input wire logic desc_valid_i,
    input wire logic [31:0] tx_descriptor_control_word_i,
    output logic desc_ready_o,
    // Transmitter side
    input wire logic tx_frame_done_i,
    output logic decode_valid_o,
    output tdcd_decode_s decode_o,
    output logic tx_done_status_o
);

    // ====================================================
    // State
    tdcd_state_s s_q;
    tdcd_state_s s_d;
    logic [31:0] w;
    logic accept;
    logic first_seg_flag;
    logic last_segment_flag;
    logic setup_flag;
    logic done_irq_request;
    logic ring_wrap_flag;
    logic chain_next_flag;
    logic crc_inhibit_eff;
    logic pad_inhibit_eff;
    logic [10:0] buf1_len;
    logic [10:0] buf2_len;
    logic buf1_used;
    logic buf2_used;
    logic [31:0] rd_mux;
    logic [1:0] rd_resp;
    logic wr_ok;

    assign w = tx_descriptor_control_word_i;
    // Software owns the word until the fetch path presents it
    // Word taken whole
    assign accept = desc_valid_i && !s_q.pause;
    assign last_segment_flag = w[TDCD_LAST_SEG_BIT];
    assign first_seg_flag = w[TDCD_FIRST_SEG_BIT];
    assign setup_flag = w[TDCD_SETUP_BIT];
    assign done_irq_request = w[TDCD_DONE_IRQ_BIT];
    assign ring_wrap_flag = w[TDCD_RING_WRAP_BIT];
    assign chain_next_flag = w[TDCD_CHAIN_BIT];

    // ====================================================
    // Buffer counts
    // Buffer 1 skip
    tdcd_buf_size #(
        .W(TDCD_BUF_W)
    ) u_buf1 (
        .count_i(w[TDCD_BUF1_LSB +: TDCD_BUF_W]),
        .ignore_i(1'b0),
        .len_o(buf1_len),
        .used_o(buf1_used)
    );

    tdcd_buf_size #(
        .W(TDCD_BUF_W)
    ) u_buf2 (
        .count_i(w[TDCD_BUF2_LSB +: TDCD_BUF_W]),
        .ignore_i(chain_next_flag),
        .len_o(buf2_len),
        .used_o(buf2_used)
    );

    // ====================================================
    // Frame-level options
    // First segment only
    // Later segments reuse what the first one carried
    assign crc_inhibit_eff = first_seg_flag ? w[TDCD_CRC_INHIBIT_BIT] : s_q.crc_inhibit;
    assign pad_inhibit_eff = first_seg_flag ? w[TDCD_PAD_INHIBIT_BIT] : s_q.pad_inhibit;

    // ====================================================
    // Register read mux
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_resp = TDCD_RESP_OKAY;
        case (s_axi_araddr_i)
            TDCD_OFS_CTRL: begin
                rd_mux[TDCD_CTRL_PAUSE_BIT] = s_q.pause;
            end
            TDCD_OFS_STATUS: begin
                rd_mux[TDCD_STAT_TX_DONE_BIT] = s_q.tx_done;
                rd_mux[TDCD_STAT_ARMED_BIT] = s_q.irq_pending;
                rd_mux[TDCD_STAT_IN_FRAME_BIT] = (s_q.frame == TDCD_IN_FRAME);
            end
            TDCD_OFS_LAST_WORD: begin
                rd_mux = s_q.last_word;
            end
            TDCD_OFS_COUNT: begin
                rd_mux[TDCD_COUNT_W-1:0] = s_q.count;
            end
            default: begin
                rd_resp = TDCD_RESP_SLVERR;
            end
        endcase
    end

    assign wr_ok = (s_q.awaddr == TDCD_OFS_CTRL) || (s_q.awaddr == TDCD_OFS_STATUS)
        || (s_q.awaddr == TDCD_OFS_LAST_WORD) || (s_q.awaddr == TDCD_OFS_COUNT);

    // ====================================================
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.dec_valid = 1'b0;

        // Write address and data taken in either order
        if (s_axi_awvalid_i && s_q.awready) begin
            s_d.aw_have = 1'b1;
            s_d.awaddr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_q.wready) begin
            s_d.w_have = 1'b1;
            s_d.wdata = s_axi_wdata_i;
            s_d.wstrb = s_axi_wstrb_i;
        end
        if (s_q.bvalid && s_axi_bready_i) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = wr_ok ? TDCD_RESP_OKAY : TDCD_RESP_SLVERR;
            if (s_q.awaddr == TDCD_OFS_CTRL && s_q.wstrb[0]) begin
                s_d.pause = s_q.wdata[TDCD_CTRL_PAUSE_BIT];
            end
            // Write one to clear; a done event below still wins
            if (s_q.awaddr == TDCD_OFS_STATUS && s_q.wstrb[0] && s_q.wdata[TDCD_STAT_TX_DONE_BIT]) begin
                s_d.tx_done = 1'b0;
            end
        end
        s_d.awready = !s_d.aw_have && !s_d.bvalid;
        s_d.wready = !s_d.w_have && !s_d.bvalid;

        // Read channel
        if (s_q.rvalid && s_axi_rready_i) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid_i && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = rd_mux;
            s_d.rresp = rd_resp;
        end
        s_d.arready = !s_d.rvalid;

        if (tx_frame_done_i && s_q.irq_pending) begin
            s_d.tx_done = 1'b1;
            s_d.irq_pending = 1'b0;
        end

        if (accept) begin
            s_d.dec_valid = 1'b1;
            s_d.last_word = w;
            s_d.count = s_q.count + 16'h0001;
            s_d.dec.frame_start = first_seg_flag;
            s_d.dec.frame_end = last_segment_flag;
            s_d.dec.setup_frame = setup_flag;
            if (first_seg_flag) begin
                s_d.frame = TDCD_IN_FRAME;
                s_d.crc_inhibit = w[TDCD_CRC_INHIBIT_BIT];
                s_d.pad_inhibit = w[TDCD_PAD_INHIBIT_BIT];
            end
            if (last_segment_flag) begin
                s_d.frame = TDCD_IDLE;
            end
            s_d.dec.filter_valid = setup_flag;
            s_d.dec.filter_mode = setup_flag ? {w[TDCD_FILTER_HIGH_BIT], w[TDCD_FILTER_LOW_BIT]} : TDCD_FILT_PERFECT16;
            s_d.dec.crc_append = !crc_inhibit_eff;
            s_d.dec.pad_short = !pad_inhibit_eff;
            s_d.dec.crc_short = !crc_inhibit_eff || !pad_inhibit_eff;
            s_d.dec.next_from_base = ring_wrap_flag;
            s_d.dec.next_from_addr2 = chain_next_flag && !ring_wrap_flag;
            s_d.dec.buf1_used = buf1_used;
            s_d.dec.buf1_len = buf1_len;
            s_d.dec.buf2_used = buf2_used;
            s_d.dec.buf2_len = buf2_len;
            s_d.dec.done_irq_armed = done_irq_request && (last_segment_flag || setup_flag);
            if (s_d.dec.done_irq_armed) begin
                s_d.irq_pending = 1'b1;
            end
        end
    end

    // ====================================================
    // Registers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_q <= '0;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready_o = s_q.awready;
    assign s_axi_wready_o = s_q.wready;
    assign s_axi_bvalid_o = s_q.bvalid;
    assign s_axi_bresp_o = s_q.bresp;
    assign s_axi_arready_o = s_q.arready;
    assign s_axi_rvalid_o = s_q.rvalid;
    assign s_axi_rdata_o = s_q.rdata;
    assign s_axi_rresp_o = s_q.rresp;
    // Pause is a flop, so ready is too
    assign desc_ready_o = !s_q.pause;
    assign decode_valid_o = s_q.dec_valid;
    assign decode_o = s_q.dec;
    assign tx_done_status_o = s_q.tx_done;

    // ====================================================
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i || !ce_i);

    sequence seq_accept;
        desc_valid_i && desc_ready_o;
    endsequence

    sequence seq_accept_armed;
        seq_accept ##0 tx_descriptor_control_word_i[TDCD_DONE_IRQ_BIT]
            && (tx_descriptor_control_word_i[TDCD_LAST_SEG_BIT] || tx_descriptor_control_word_i[TDCD_SETUP_BIT]);
    endsequence

    chk_done_sets_status: assert property (
        tx_frame_done_i && s_q.irq_pending |=> tx_done_status_o
    ) else $error("done request did not raise transmit-done status");

    chk_irq_arm: assert property (
        seq_accept_armed |=> s_q.irq_pending && decode_o.done_irq_armed
    ) else $error("armed done request not held pending");

    chk_irq_gate: assert property (
        seq_accept ##0 !tx_descriptor_control_word_i[TDCD_LAST_SEG_BIT]
            && !tx_descriptor_control_word_i[TDCD_SETUP_BIT] && !s_q.irq_pending
        |=> !s_q.irq_pending && !decode_o.done_irq_armed
    ) else $error("done request armed without last segment or setup");

    chk_frame_end: assert property (
        seq_accept ##0 tx_descriptor_control_word_i[TDCD_LAST_SEG_BIT]
        |=> decode_o.frame_end && s_q.frame == TDCD_IDLE
    ) else $error("last segment did not close frame");

    chk_frame_start: assert property (
        seq_accept ##0 tx_descriptor_control_word_i[TDCD_FIRST_SEG_BIT]
            && !tx_descriptor_control_word_i[TDCD_LAST_SEG_BIT]
        |=> decode_o.frame_start && s_q.frame == TDCD_IN_FRAME
    ) else $error("first segment did not open frame");

    chk_filter_map: assert property (
        seq_accept ##0 tx_descriptor_control_word_i[TDCD_SETUP_BIT]
        |=> decode_o.filter_mode == {$past(tx_descriptor_control_word_i[TDCD_FILTER_HIGH_BIT]),
            $past(tx_descriptor_control_word_i[TDCD_FILTER_LOW_BIT])}
    ) else $error("filter type bits mapped wrongly");

    chk_filter_gate: assert property (
        decode_valid_o && !decode_o.setup_frame |-> !decode_o.filter_valid && decode_o.filter_mode == 2'h0
    ) else $error("filter type used outside setup frame");

    chk_crc_first_only: assert property (
        seq_accept ##0 !tx_descriptor_control_word_i[TDCD_FIRST_SEG_BIT]
        |=> decode_o.crc_append == !$past(s_q.crc_inhibit)
    ) else $error("CRC inhibit taken from non-first segment");

    chk_pad_forces_crc: assert property (
        decode_valid_o && decode_o.pad_short |-> decode_o.crc_short
    ) else $error("padding without CRC");

    chk_wrap_wins: assert property (
        seq_accept ##0 tx_descriptor_control_word_i[TDCD_RING_WRAP_BIT]
        |=> decode_o.next_from_base && !decode_o.next_from_addr2
    ) else $error("chaining taken over ring wrap");

    chk_buf2_chain: assert property (
        seq_accept ##0 tx_descriptor_control_word_i[TDCD_CHAIN_BIT]
        |=> !decode_o.buf2_used && decode_o.buf2_len == 11'h000
    ) else $error("buffer 2 used while chained");

    chk_buf1_zero: assert property (
        seq_accept ##0 tx_descriptor_control_word_i[10:0] == 11'h000 |=> !decode_o.buf1_used
    ) else $error("zero length buffer 1 not skipped");

    chk_no_wrap: assert property (
        seq_accept ##0 !tx_descriptor_control_word_i[TDCD_RING_WRAP_BIT]
        |=> !decode_o.next_from_base
    ) else $error("ring wrap reported without flag");

endmodule

// ### rtl/tdcd_pkg.sv
package tdcd_pkg;

    // ====================================================
    // Descriptor control word layout
    localparam int unsigned TDCD_DONE_IRQ_BIT = 31;
    localparam int unsigned TDCD_LAST_SEG_BIT = 30;
    localparam int unsigned TDCD_FIRST_SEG_BIT = 29;
    localparam int unsigned TDCD_FILTER_HIGH_BIT = 28;
    localparam int unsigned TDCD_SETUP_BIT = 27;
    localparam int unsigned TDCD_CRC_INHIBIT_BIT = 26;
    localparam int unsigned TDCD_RING_WRAP_BIT = 25;
    localparam int unsigned TDCD_CHAIN_BIT = 24;
    localparam int unsigned TDCD_PAD_INHIBIT_BIT = 23;
    localparam int unsigned TDCD_FILTER_LOW_BIT = 22;
    localparam int unsigned TDCD_BUF2_LSB = 11;
    localparam int unsigned TDCD_BUF1_LSB = 0;
    localparam int unsigned TDCD_BUF_W = 11;

    // ====================================================
    // Filter type encodings
    localparam logic [1:0] TDCD_FILT_PERFECT16 = 2'h0;
    localparam logic [1:0] TDCD_FILT_HASH_ONE = 2'h1;
    localparam logic [1:0] TDCD_FILT_INVERSE = 2'h2;
    localparam logic [1:0] TDCD_FILT_HASH_ONLY = 2'h3;

    // ====================================================
    // Register map, byte addresses
    localparam int unsigned TDCD_ADDR_W = 8;
    localparam logic [7:0] TDCD_OFS_CTRL = 8'h00;
    localparam logic [7:0] TDCD_OFS_STATUS = 8'h04;
    localparam logic [7:0] TDCD_OFS_LAST_WORD = 8'h08;
    localparam logic [7:0] TDCD_OFS_COUNT = 8'h0C;
    localparam int unsigned TDCD_CTRL_PAUSE_BIT = 0;
    localparam int unsigned TDCD_STAT_TX_DONE_BIT = 0;
    localparam int unsigned TDCD_STAT_ARMED_BIT = 1;
    localparam int unsigned TDCD_STAT_IN_FRAME_BIT = 2;
    localparam int unsigned TDCD_COUNT_W = 16;
    localparam logic [1:0] TDCD_RESP_OKAY = 2'h0;
    localparam logic [1:0] TDCD_RESP_SLVERR = 2'h2;

    // ====================================================
    // Types
    typedef enum logic [0:0] {
        TDCD_IDLE,
        TDCD_IN_FRAME
    } tdcd_frame_e;

    typedef struct packed {
        logic frame_start;
        logic frame_end;
        logic setup_frame;
        logic filter_valid;
        logic [1:0] filter_mode;
        logic crc_append;
        logic pad_short;
        logic crc_short;
        logic next_from_base;
        logic next_from_addr2;
        logic buf1_used;
        logic [10:0] buf1_len;
        logic buf2_used;
        logic [10:0] buf2_len;
        logic done_irq_armed;
    } tdcd_decode_s;

    typedef struct packed {
        logic dec_valid;
        tdcd_decode_s dec;
        tdcd_frame_e frame;
        logic crc_inhibit;
        logic pad_inhibit;
        logic irq_pending;
        logic tx_done;
        logic pause;
        logic [31:0] last_word;
        logic [15:0] count;
        logic awready;
        logic wready;
        logic aw_have;
        logic w_have;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } tdcd_state_s;

endpackage

// ### rtl/tdcd_buf_size.sv
`timescale 1ns/1ps
module tdcd_buf_size
    import tdcd_pkg::*;
#(
    parameter int unsigned W = TDCD_BUF_W
) (
    // Count field
    input wire logic [W-1:0] count_i,
    input wire logic ignore_i,
    // Decoded buffer
    output logic [W-1:0] len_o,
    output logic used_o
);

    // A zero count means the buffer is skipped
    assign used_o = !ignore_i && (count_i != '0);
    assign len_o = used_o ? count_i : '0;

endmodule

// ### testbench/tdcd_host_mem.sv
`timescale 1ns/1ps
module tdcd_host_mem (
    // Clock
    input wire logic clk_i,
    // Descriptor fetch
    input wire logic desc_ready_i,
    output logic desc_valid_o,
    output logic [31:0] word_o
);
    initial begin
        desc_valid_o = 1'b0;
        word_o = 32'h0;
    end

    // ====================================================
    // Word hand-over
    // Complete word offered
    task automatic send(input logic [31:0] w);
        @(posedge clk_i);
        desc_valid_o <= 1'b1;
        word_o <= w;
        do @(posedge clk_i); while (desc_ready_i !== 1'b1);
        desc_valid_o <= 1'b0;
        // Inverted so a stale word never passes for a new one
        word_o <= ~w;
    endtask
endmodule

// ### testbench/tb_tx_descriptor_control_decode.sv
`timescale 1ns/1ps
module tb_tx_descriptor_control_decode import tdcd_pkg::*;;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, word;
    logic desc_valid, desc_ready, dec_valid, done_stat;
    logic frame_done = 1'b0;
    logic ce = 1'b1;
    tdcd_decode_s dec;
    logic ci = 1'b0, pi = 1'b0;
    int n_fail = 0, cmp_count = 0, n_words = 0;

    always #12.5 clk_i = ~clk_i;

    tdcd_host_mem mem (.clk_i(clk_i), .desc_ready_i(desc_ready), .desc_valid_o(desc_valid), .word_o(word));

    tdcd_decode uut (
        .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
        .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_araddr_i(araddr),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .desc_valid_i(desc_valid), .tx_descriptor_control_word_i(word), .desc_ready_o(desc_ready),
        .tx_frame_done_i(frame_done), .decode_valid_o(dec_valid), .decode_o(dec),
        .tx_done_status_o(done_stat)
    );

    // ====================================================
    // Compare and report
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_dec(input tdcd_decode_s exp);
        cmp_count++;
        if (dec_valid !== 1'b1 || dec !== exp) begin
            n_fail++;
            $display("FAIL %0t decode %h expected %h", $time, dec, exp);
        end
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ====================================================
    // Expected decode; inhibits latch from first segments only
    function automatic tdcd_decode_s exp_dec(input logic [31:0] w);
        tdcd_decode_s e;
        if (w[29]) begin
            ci = w[26];
            pi = w[23];
        end
        e = '0;
        e.frame_start = w[29];
        e.frame_end = w[30];
        e.setup_frame = w[27];
        e.filter_valid = w[27];
        e.filter_mode = w[27] ? {w[28], w[22]} : 2'h0;
        e.crc_append = !ci;
        e.pad_short = !pi;
        e.crc_short = !ci || !pi;
        e.next_from_base = w[25];
        e.next_from_addr2 = w[24] && !w[25];
        e.buf1_used = |w[10:0];
        e.buf1_len = w[10:0];
        e.buf2_used = !w[24] && |w[21:11];
        e.buf2_len = e.buf2_used ? w[21:11] : 11'h000;
        e.done_irq_armed = w[31] && (w[30] || w[27]);
        return e;
    endfunction

    // ====================================================
    // Bus master
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w;
        @(posedge clk_i);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        bready <= 1'b1;
        aw = 1'b1;
        w = 1'b1;
        while (aw || w) begin
            @(posedge clk_i);
            if (aw && awready === 1'b1) begin
                awvalid <= 1'b0;
                aw = 1'b0;
            end
            if (w && wready === 1'b1) begin
                wvalid <= 1'b0;
                w = 1'b0;
            end
        end
        do @(posedge clk_i); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge clk_i); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk_i); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic send_word(input logic [31:0] w);
        mem.send(w);
        n_words++;
        #1;
        cmp_dec(exp_dec(w));
    endtask

    // ====================================================
    // Scenarios
    task automatic t_fields();
        logic [31:0] tbl[8] = '{32'h68000010, 32'h68400010, 32'h78000010, 32'h78400010,
                                32'h34C20000, 32'h073FF805, 32'h410087FF, 32'h6600003C};
        foreach (tbl[i]) send_word(tbl[i]);
    endtask

    task automatic pulse_done();
        @(posedge clk_i);
        frame_done <= 1'b1;
        @(posedge clk_i);
        frame_done <= 1'b0;
        #1;
    endtask

    task automatic t_done();
        logic [31:0] d;
        logic [1:0] r;
        // Done request on a first segment without last segment is dropped
        send_word(32'hA0000010);
        pulse_done();
        cmp_val({31'h0, done_stat}, 32'h0);
        axi_rd(TDCD_OFS_STATUS, d, r);
        cmp_val(d, 32'h4);
        send_word(32'hC0000010);
        axi_rd(TDCD_OFS_STATUS, d, r);
        cmp_val(d, 32'h2);
        pulse_done();
        cmp_val({31'h0, done_stat}, 32'h1);
        axi_rd(TDCD_OFS_STATUS, d, r);
        cmp_val(d, 32'h1);
        axi_wr(TDCD_OFS_STATUS, 32'h1, r);
        axi_rd(TDCD_OFS_STATUS, d, r);
        cmp_val(d, 32'h0);
        // Setup frame arms without last segment
        send_word(32'h88000000);
        pulse_done();
        cmp_val({31'h0, done_stat}, 32'h1);
    endtask

    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(TDCD_OFS_COUNT, d, r);
        cmp_val(d, n_words);
        cmp_val({30'h0, r}, {30'h0, TDCD_RESP_OKAY});
        axi_rd(TDCD_OFS_LAST_WORD, d, r);
        cmp_val(d, 32'h88000000);
        axi_rd(8'h40, d, r);
        cmp_val({r, d[29:0]}, {TDCD_RESP_SLVERR, 30'h0});
        axi_wr(8'h40, 32'hFFFFFFFF, r);
        cmp_val({30'h0, r}, {30'h0, TDCD_RESP_SLVERR});
        // Pause holds the fetch path off
        axi_wr(TDCD_OFS_CTRL, 32'h1, r);
        #1;
        cmp_val({30'h0, r}, {30'h0, TDCD_RESP_OKAY});
        cmp_val({31'h0, desc_ready}, 32'h0);
        // A word offered while paused waits until the pause is lifted
        fork
            send_word(32'h60000001);
            begin
                repeat (4) @(posedge clk_i);
                #1;
                cmp_val({31'h0, dec_valid}, 32'h0);
                axi_wr(TDCD_OFS_CTRL, 32'h0, r);
                #1;
                cmp_val({31'h0, desc_ready}, 32'h1);
            end
        join
    endtask

    task automatic t_ce();
        logic [31:0] d;
        logic [1:0] r;
        // Enable low freezes the block, so the offered word is lost
        @(posedge clk_i);
        ce <= 1'b0;
        mem.send(32'h60000001);
        #1;
        cmp_val({31'h0, dec_valid}, 32'h0);
        @(posedge clk_i);
        ce <= 1'b1;
        axi_rd(TDCD_OFS_COUNT, d, r);
        cmp_val(d, n_words);
    endtask

    initial begin
        #(25 * 6000);
        n_fail++;
        stop_test();
    end

    initial begin
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        t_fields();
        t_done();
        t_regs();
        t_ce();
        stop_test();
    end
endmodule
